// ===== rtl/vcocal_pkg.sv
// Package with register map, field positions and timing constants of the calibration sequencer.
package vcocal_pkg;
  localparam int ADDR_W = 5;
  localparam int DATA_W = 24;
  // Register offsets.
  localparam logic [4:0] REG_INTEGER = 5'h03;
  localparam logic [4:0] REG_FRACTION = 5'h04;
  localparam logic [4:0] REG_VCO_PORT = 5'h05;
  localparam logic [4:0] REG_MODE = 5'h06;
  localparam logic [4:0] REG_CAL_CFG = 5'h0a;
  localparam logic [4:0] REG_BAND_STATUS = 5'h10;
  localparam logic [4:0] REG_SEQ_STATUS = 5'h12;
  // Field positions.
  localparam int MODE_FRAC_BIT = 11;
  localparam int CFG_CAL_OFF_BIT = 11;
  localparam int CFG_RES_LSB = 0;
  localparam int CFG_WAIT_LSB = 3;
  localparam int CFG_DIV_LSB = 13;
  // Reset values.
  localparam logic [23:0] CAL_CFG_RESET = 24'h004012;
  localparam logic [23:0] MODE_RESET = 24'h000000;
  // Timing and band width.
  localparam int LINK_BITS = 16;
  localparam int STEP_XFER_CYCLES = 20;
  localparam int WAIT_UNIT_CYCLES = 20;
  localparam int CAL_STEPS = 8;
  localparam int BAND_W = 8;
endpackage : vcocal_pkg

// ===== rtl/vcocal_seq.sv
// Frequency change sequencer with VCO band autocalibration and internal VCO serial link.
//
// Strobed register access and the register addresses are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
// Notes on behaviour
// [R1] Host keeps N and compare rate legal.
// [R2] Host keeps calibration clock at most 50MHz.
// [R3] Divided clock times calibration and link.
// [R4] Resolution code selects 2^n measurement window; codes 4 to 7 here give 2^(n+1).
// [R5] Load pending fraction after band chosen.
// [R6] Chosen band readable after each calibration.
// [R7] Calibration off: band and frequency immediate.
// [R8] Calibration off: VCO port word forwarded.
// [R9] Port transfer takes sixteen link clocks.
// [R10] Link clock is reference over 1,4,16,32.
// [R11] Mode bit picks fractional or integer trigger.
// [R12] Integer write triggers change in integer mode.
// [R13] Fractional write starts calibration, loads later.
// [R14] Calibration off: fractional write loads immediately.
// [R15] Host writes fraction last every change.
// [R16] Host writes port only when needed.
// [R17] Integer write calibrates then loads prescaler.
// [R18] Host sets band before manual integer write.
// [R19] Host writes port only for band/config.
// [R20] Eight steps: wait, measure, 20-cycle transfer.
// [R21] Measurement counts VCO over ref*R*2^n; codes 4 to 7 here use 2^(n+1).
module vcocal_seq #(
  parameter int DATA_W = vcocal_pkg::DATA_W
) (
  // Clock and reset.
  input wire logic CLK_IN,
  input wire logic RESET_IN,
  // Register port.
  input wire logic [4:0] ADDR_IN,
  input wire logic [DATA_W-1:0] WDATA_IN,
  input wire logic WR_IN,
  input wire logic RD_IN,
  output logic [DATA_W-1:0] RDATA_OUT,
  // Phase compare tick and VCO count pulse from the analog side.
  input wire logic PD_TICK_IN,
  input wire logic VCO_PULSE_IN,
  // Loaded frequency words.
  output logic [DATA_W-1:0] PRESCALER_OUT,
  output logic [DATA_W-1:0] MODULATOR_OUT,
  output logic LOAD_OUT,
  // Internal VCO serial link and sequencer busy flag.
  output logic LINK_CLK_OUT,
  output logic LINK_DATA_OUT,
  output logic LINK_LATCH_OUT,
  output logic BUSY_OUT
);
  typedef enum logic [4:0] {
    S_IDLE = 5'b00001,
    S_WAIT = 5'b00010,
    S_MEAS = 5'b00100,
    S_XFER = 5'b01000,
    S_PORT = 5'b10000
  } vcocal_state_t;

  vcocal_state_t state;
  vcocal_state_t next_state;
  logic [DATA_W-1:0] int_reg;
  logic [DATA_W-1:0] frac_reg;
  logic [DATA_W-1:0] port_reg;
  logic [DATA_W-1:0] mode_reg;
  logic [DATA_W-1:0] cfg_reg;
  logic [vcocal_pkg::BAND_W-1:0] band;
  logic [3:0] step;
  logic [8:0] win_cnt;
  logic [DATA_W-1:0] vco_cnt;
  logic [7:0] cyc_cnt;
  logic [4:0] div_cnt;
  logic [15:0] shreg;
  logic [4:0] bit_cnt;
  logic pend_port;
  logic [2:0] vco_sync;

  // Returns 2^n for resolution codes 0 to 3 and 2^(n+1) for codes 4 to 7.
  function automatic logic [8:0] window_len(input logic [2:0] code);
    case (code)
      3'h0: window_len = 9'h001;
      3'h1: window_len = 9'h002;
      3'h2: window_len = 9'h004;
      3'h3: window_len = 9'h008;
      3'h4: window_len = 9'h020;
      3'h5: window_len = 9'h040;
      3'h6: window_len = 9'h080;
      default: window_len = 9'h100;
    endcase
  endfunction

  wire cal_off = cfg_reg[vcocal_pkg::CFG_CAL_OFF_BIT];
  wire frac_mode = mode_reg[vcocal_pkg::MODE_FRAC_BIT];
  wire [1:0] div_sel = cfg_reg[vcocal_pkg::CFG_DIV_LSB +: 2];
  wire [6:0] wait_k = cfg_reg[vcocal_pkg::CFG_WAIT_LSB +: 7];
  wire [8:0] win_len = window_len(cfg_reg[vcocal_pkg::CFG_RES_LSB +: 3]); // [R4]
  // Divider terminal count: 2^m - 1 for m of 0, 2, 4, 5.
  wire [4:0] div_top = (div_sel == 2'h0) ? 5'h00 : (div_sel == 2'h1) ? 5'h03 :
                       (div_sel == 2'h2) ? 5'h0f : 5'h1f; // [R10]
  // A smaller ratio written while the counter sits above its new top restarts at once instead of waiting for a wrap.
  wire tick = (div_cnt >= div_top); // [R3]
  wire wr_int = WR_IN && (ADDR_IN == vcocal_pkg::REG_INTEGER);
  wire wr_frac = WR_IN && (ADDR_IN == vcocal_pkg::REG_FRACTION);
  wire wr_port = WR_IN && (ADDR_IN == vcocal_pkg::REG_VCO_PORT);
  // The trigger register depends on the mode bit.
  wire trigger = frac_mode ? wr_frac : wr_int; // [R11] [R12]
  wire start_cal = trigger && !cal_off && (state == S_IDLE); // [R13] [R17]
  wire direct_load = trigger && cal_off; // [R7] [R14]
  wire [8:0] wait_len = 9'(vcocal_pkg::WAIT_UNIT_CYCLES) * (9'(wait_k) + 9'h001);
  // Expected count is N times the window length from the integer part alone; the fraction is not used.
  wire [DATA_W-1:0] expect_cnt = DATA_W'(int_reg * win_len);
  wire vco_edge = vco_sync[1] ^ vco_sync[2];
  // The edge seen on the closing tick still belongs to the window, so the count spans exactly win_len periods.
  wire [DATA_W-1:0] meas_cnt = vco_cnt + DATA_W'(vco_edge); // [R21]
  wire meas_done = (state == S_MEAS) && PD_TICK_IN && (win_cnt == win_len);
  wire xfer_done = tick && (bit_cnt == 5'h00) && (cyc_cnt == 8'h00);
  wire last_step = (step == 4'(vcocal_pkg::CAL_STEPS - 1));
  wire [DATA_W-1:0] rd_mux =
    (ADDR_IN == vcocal_pkg::REG_INTEGER) ? int_reg :
    (ADDR_IN == vcocal_pkg::REG_FRACTION) ? frac_reg :
    (ADDR_IN == vcocal_pkg::REG_VCO_PORT) ? port_reg :
    (ADDR_IN == vcocal_pkg::REG_MODE) ? mode_reg :
    (ADDR_IN == vcocal_pkg::REG_CAL_CFG) ? cfg_reg :
    (ADDR_IN == vcocal_pkg::REG_BAND_STATUS) ? DATA_W'(band) : // [R6]
    (ADDR_IN == vcocal_pkg::REG_SEQ_STATUS) ? DATA_W'(state != S_IDLE) : '0;

  always_comb
  begin
    next_state = state;
    case (state)
      S_IDLE:
      begin
        if (start_cal)
          next_state = S_WAIT;
        else if (pend_port && tick)
          next_state = S_PORT;
      end
      S_WAIT:
        if (tick && cyc_cnt == 8'h00) next_state = S_MEAS;
      S_MEAS:
        if (meas_done) next_state = S_XFER;
      S_XFER:
        if (cyc_cnt == 8'h00 && tick) next_state = last_step ? S_IDLE : S_WAIT; // [R20]
      S_PORT:
        if (xfer_done) next_state = S_IDLE;
      default: next_state = S_IDLE;
    endcase
  end

  always_ff @(posedge CLK_IN)
  begin
    if (RESET_IN)
      div_cnt <= 5'h00;
    else
      div_cnt <= tick ? 5'h00 : div_cnt + 5'h01; // [R10]
  end

  always_ff @(posedge CLK_IN)
  begin
    if (RESET_IN)
      vco_sync <= 3'h0;
    else
      vco_sync <= {vco_sync[1:0], VCO_PULSE_IN};
  end

  always_ff @(posedge CLK_IN)
  begin
    if (RESET_IN)
    begin
      int_reg <= '0;
      frac_reg <= '0;
      port_reg <= '0;
      mode_reg <= vcocal_pkg::MODE_RESET;
      cfg_reg <= vcocal_pkg::CAL_CFG_RESET;
    end
    else if (WR_IN)
    begin
      if (wr_int) int_reg <= WDATA_IN;
      if (wr_frac) frac_reg <= WDATA_IN;
      if (wr_port) port_reg <= WDATA_IN;
      if (ADDR_IN == vcocal_pkg::REG_MODE) mode_reg <= WDATA_IN;
      if (ADDR_IN == vcocal_pkg::REG_CAL_CFG) cfg_reg <= WDATA_IN;
    end
  end

  always_ff @(posedge CLK_IN)
  begin
    if (RESET_IN)
      RDATA_OUT <= '0;
    else
      RDATA_OUT <= RD_IN ? rd_mux : '0;
  end

  // A port write with calibration off waits for a free link; while a calibration is running it is held, not lost.
  always_ff @(posedge CLK_IN)
  begin
    if (RESET_IN)
      pend_port <= 1'b0;
    else if (wr_port && cal_off)
      pend_port <= 1'b1; // [R8]
    else if (state == S_IDLE && tick && !start_cal)
      pend_port <= 1'b0;
  end

  always_ff @(posedge CLK_IN)
  begin
    if (RESET_IN)
    begin
      state <= S_IDLE;
      step <= 4'h0;
      band <= '0;
      cyc_cnt <= 8'h00;
      win_cnt <= 9'h000;
      vco_cnt <= '0;
      shreg <= 16'h0000;
      bit_cnt <= 5'h00;
    end
    else
    begin
      state <= next_state;
      case (state)
        S_IDLE:
        begin
          if (start_cal)
          begin
            step <= 4'h0;
            band <= 8'h80;
            cyc_cnt <= 8'(wait_len - 9'h001);
          end
          else if (pend_port && tick)
          begin
            shreg <= port_reg[15:0];
            bit_cnt <= 5'(vcocal_pkg::LINK_BITS - 1); // [R9]
            cyc_cnt <= 8'h00;
          end
        end
        S_WAIT:
        begin
          if (tick) cyc_cnt <= cyc_cnt - 8'h01;
          win_cnt <= 9'h000;
          vco_cnt <= '0;
        end
        S_MEAS:
        begin
          if (PD_TICK_IN) win_cnt <= win_cnt + 9'h001; // [R21]
          if (vco_edge && win_cnt != 9'h000) vco_cnt <= vco_cnt + 1'b1;
          if (meas_done)
          begin
            // Successive approximation: keep a bit when the VCO ran slow.
            if (meas_cnt >= expect_cnt) band[3'(7 - step)] <= 1'b0;
            if (!last_step) band[3'(6 - step)] <= 1'b1;
            cyc_cnt <= 8'(vcocal_pkg::STEP_XFER_CYCLES - 1); // [R20]
            shreg <= {8'h00, band};
          end
        end
        S_XFER:
          if (tick)
          begin
            cyc_cnt <= cyc_cnt - 8'h01;
            shreg <= {shreg[14:0], 1'b0};
            if (cyc_cnt == 8'h00)
            begin
              step <= last_step ? 4'h0 : step + 4'h1; // [R20]
              cyc_cnt <= 8'(wait_len - 9'h001);
            end
          end
        S_PORT:
          if (tick && bit_cnt != 5'h00)
          begin
            shreg <= {shreg[14:0], 1'b0};
            bit_cnt <= bit_cnt - 5'h01; // [R9]
          end
        default: step <= 4'h0;
      endcase
    end
  end

  wire cal_finish = (state == S_XFER) && (next_state == S_IDLE);

  always_ff @(posedge CLK_IN)
  begin
    if (RESET_IN)
    begin
      PRESCALER_OUT <= '0;
      MODULATOR_OUT <= '0;
      LOAD_OUT <= 1'b0;
    end
    else
    begin
      LOAD_OUT <= direct_load || cal_finish;
      if (direct_load || cal_finish) // [R5] [R13] [R14] [R17]
      begin
        PRESCALER_OUT <= (direct_load && !frac_mode) ? WDATA_IN : int_reg;
        MODULATOR_OUT <= (direct_load && frac_mode) ? WDATA_IN : frac_reg;
      end
    end
  end

  always_ff @(posedge CLK_IN)
  begin
    if (RESET_IN)
    begin
      LINK_CLK_OUT <= 1'b0;
      LINK_DATA_OUT <= 1'b0;
      LINK_LATCH_OUT <= 1'b0;
      BUSY_OUT <= 1'b0;
    end
    else
    begin
      LINK_CLK_OUT <= tick && (state == S_XFER || state == S_PORT); // [R3]
      LINK_DATA_OUT <= shreg[15];
      LINK_LATCH_OUT <= xfer_done && (state == S_PORT);
      BUSY_OUT <= (next_state != S_IDLE);
    end
  end

  sequence port_write_s;
    wr_port && cal_off;
  endsequence

  cal_start_busy_a: assert property (@(posedge CLK_IN) disable iff (RESET_IN) // [R13]
    start_cal |=> state == S_WAIT)
    else $error("calibration did not start");
  direct_load_a: assert property (@(posedge CLK_IN) disable iff (RESET_IN) // [R14]
    (direct_load && frac_mode) |=> (LOAD_OUT && MODULATOR_OUT == $past(WDATA_IN)))
    else $error("fraction not loaded at once");
  int_direct_a: assert property (@(posedge CLK_IN) disable iff (RESET_IN) // [R7]
    (direct_load && !frac_mode) |=> (LOAD_OUT && PRESCALER_OUT == $past(WDATA_IN)))
    else $error("prescaler not loaded at once");
  port_forward_a: assert property (@(posedge CLK_IN) disable iff (RESET_IN) // [R8]
    port_write_s |=> pend_port)
    else $error("port word not queued");
  no_load_cal_a: assert property (@(posedge CLK_IN) disable iff (RESET_IN) // [R5]
    (state == S_MEAS || state == S_WAIT) |-> !LOAD_OUT || $past(direct_load))
    else $error("load during calibration");
  divider_range_a: assert property (@(posedge CLK_IN) disable iff (RESET_IN) // [R10]
    div_cnt <= div_top || $changed(div_sel))
    else $error("divider out of range");
  step_count_a: assert property (@(posedge CLK_IN) disable iff (RESET_IN) // [R20]
    step < 4'(vcocal_pkg::CAL_STEPS))
    else $error("too many steps");
  mode_trigger_a: assert property (@(posedge CLK_IN) disable iff (RESET_IN) // [R11]
    (wr_int && frac_mode && state == S_IDLE) |=> state != S_WAIT)
    else $error("integer write triggered in fractional mode");
  window_len_a: assert property (@(posedge CLK_IN) disable iff (RESET_IN) // [R4]
    (state == S_MEAS) |-> win_cnt <= win_len)
    else $error("window length wrong");
endmodule // vcocal_seq
`default_nettype wire

// ===== verif/vcocal_analog_model.sv
// Behavioural model of the analog side: phase compare ticks and a free-running VCO.
`timescale 1ns/100ps
`default_nettype none
module vcocal_analog_model #(
  parameter int PD_DIV = 17,
  parameter int VCO_HALF_NS = 42
) (
  // Clock and reset.
  input wire logic clk_in,
  input wire logic rst_in,
  // Analog side outputs.
  output logic pd_tick_out,
  output logic vco_pulse_out
);
  int cnt;
  // The VCO runs unrelated to the clock; edges stay over 40 ns apart so none is lost in the synchroniser.
  initial
  begin
    vco_pulse_out = 1'b0;
    forever #(VCO_HALF_NS) vco_pulse_out = ~vco_pulse_out;
  end
  always @(posedge clk_in)
  begin
    cnt <= (rst_in || cnt == PD_DIV - 1) ? 0 : cnt + 1;
    pd_tick_out <= !rst_in && cnt == PD_DIV - 1;
  end
endmodule // vcocal_analog_model
`default_nettype wire

// ===== verif/tb_vcocal_seq.sv
// Self-checking testbench of the frequency change sequencer.
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin n_fail++; \
  $display("MISMATCH %s expected %0h seen %0h", nm, ex, got); end end
module tb_vcocal_seq;
  localparam int PD_DIV = 17;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [4:0] addr = 5'h00;
  logic [23:0] wdata = 24'h000000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic pd_tick, vco_pulse, load, link_clk, link_data, link_latch, busy;
  logic [23:0] rdata, prescaler, modulator, r, v;
  logic [31:0] seed = 32'h0000ccc2;
  logic [15:0] sh;
  int n_fail = 0;
  int compares = 0;
  int dur[8];
  int divs[4] = '{1, 4, 16, 32};
  int nexp[8] = '{0, 1, 2, 3, 5, 6, 7, 8};
  int n, span, first, ex;

  vcocal_analog_model #(.PD_DIV(PD_DIV)) u_vcocal_analog_model (.clk_in(clk), .rst_in(rst),
    .pd_tick_out(pd_tick), .vco_pulse_out(vco_pulse));
  vcocal_seq u_vcocal_seq (.CLK_IN(clk), .RESET_IN(rst), .ADDR_IN(addr), .WDATA_IN(wdata), .WR_IN(wr),
    .RD_IN(rd), .RDATA_OUT(rdata), .PD_TICK_IN(pd_tick), .VCO_PULSE_IN(vco_pulse),
    .PRESCALER_OUT(prescaler), .MODULATOR_OUT(modulator), .LOAD_OUT(load), .LINK_CLK_OUT(link_clk),
    .LINK_DATA_OUT(link_data), .LINK_LATCH_OUT(link_latch), .BUSY_OUT(busy));

  initial
  begin
    forever #20 clk = ~clk;
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction

  function automatic logic [23:0] cfg(input int dv, input logic off, input int res);
    return {9'h000, 2'(dv), 1'b0, off, 1'b0, 7'h00, 3'(res)};
  endfunction

  task automatic step;
    @(posedge clk);
    #1;
  endtask

  task automatic wr_reg(input logic [4:0] a, input logic [23:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask

  task automatic rd_reg(input logic [4:0] a, output logic [23:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask

  task automatic wait_load(input int lim);
    for (int c = 0; c < lim && load !== 1'b1; c++) step;
  endtask

  task automatic port_xfer(input int dv);
    wr_reg(vcocal_pkg::REG_CAL_CFG, cfg(dv, 1'b1, 0));
    seed = xs(seed);
    v = seed[23:0];
    wr_reg(vcocal_pkg::REG_VCO_PORT, v);
    n = 0;
    first = -1;
    span = 0;
    sh = 16'h0000;
    for (int c = 0; c < 1280 && link_latch !== 1'b1; c++)
    begin
      step;
      if (link_clk === 1'b1)
      begin
        sh = {sh[14:0], link_data};
        first = (first < 0) ? c : first;
        span = c - first;
        n++;
      end
    end
    `CHK("link latch", 1'b1, link_latch)
    `CHK("link clocks", 16, n)
    `CHK("link word", v[15:0], sh)
    `CHK("link spacing", 15 * divs[dv], span)
  endtask

  task automatic cal_int(input int res, input logic [23:0] val);
    int c;
    wr_reg(vcocal_pkg::REG_CAL_CFG, cfg(0, 1'b0, res));
    wr_reg(vcocal_pkg::REG_MODE, 24'h000000);
    v = prescaler;
    wr_reg(vcocal_pkg::REG_INTEGER, val);
    step;
    step;
    `CHK("busy", 1'b1, busy)
    `CHK("prescaler held", v, prescaler)
    rd_reg(vcocal_pkg::REG_SEQ_STATUS, r);
    `CHK("busy bit", 1'b1, r[0])
    n = 0;
    for (c = 0; c < 60000 && busy === 1'b1 && load !== 1'b1; c++)
    begin
      step;
      n += (link_clk === 1'b1) ? 1 : 0;
    end
    wait_load(4);
    `CHK("cal load", 1'b1, load)
    `CHK("prescaler", val, prescaler)
    `CHK("cal link clocks", vcocal_pkg::CAL_STEPS * vcocal_pkg::STEP_XFER_CYCLES, n)
    dur[res] = c;
    rd_reg(vcocal_pkg::REG_BAND_STATUS, r);
    `CHK("band", (val == 24'h000010) ? 8'h00 : 8'hff, r[7:0])
  endtask

  task automatic test_done;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  initial
  begin
    #3800000;
    n_fail++;
    test_done;
  end

  initial
  begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    step;
    `CHK("busy idle", 1'b0, busy)
    rd_reg(vcocal_pkg::REG_CAL_CFG, r);
    `CHK("cfg reset", vcocal_pkg::CAL_CFG_RESET, r)
    step;
    `CHK("rdata one cycle", 24'h000000, rdata)
    rd_reg(vcocal_pkg::REG_MODE, r);
    `CHK("mode reset", vcocal_pkg::MODE_RESET, r)
    rd_reg(vcocal_pkg::REG_BAND_STATUS, r);
    `CHK("band reset", 24'h000000, r)
    rd_reg(5'h1f, r);
    `CHK("unmapped", 24'h000000, r)
    $display("test reset done");
    for (int dv = 0; dv < 4; dv++) port_xfer(dv);
    $display("test link done");
    for (int md = 0; md < 2; md++)
    begin
      wr_reg(vcocal_pkg::REG_MODE, md ? 24'h000800 : 24'h000000);
      seed = xs(seed);
      v = seed[23:0] | 24'h000020;
      wr_reg(md ? vcocal_pkg::REG_FRACTION : vcocal_pkg::REG_INTEGER, v);
      wait_load(2);
      `CHK("load", 1'b1, load)
      `CHK("word", v, md ? modulator : prescaler)
      wr_reg(md ? vcocal_pkg::REG_INTEGER : vcocal_pkg::REG_FRACTION, 24'h000014);
      repeat (3)
      begin
        step;
        `CHK("no load", 1'b0, load)
      end
    end
    $display("test manual done");
    for (int rs = 0; rs < 8; rs++) cal_int(rs, rs[0] ? 24'h00ffff : 24'h000010);
    for (int rs = 1; rs < 8; rs++)
    begin
      ex = 8 * ((1 << nexp[rs]) - 1) * PD_DIV;
      `CHK("cal window", 1'b1, (dur[rs] - dur[0] - ex) inside {[-272:272]})
    end
    $display("test integer cal done");
    wr_reg(vcocal_pkg::REG_MODE, 24'h000800);
    wr_reg(vcocal_pkg::REG_INTEGER, 24'h000014);
    step;
    step;
    `CHK("int no trigger", 1'b0, busy)
    // The shortest window keeps this last calibration well inside the run budget.
    wr_reg(vcocal_pkg::REG_CAL_CFG, cfg(0, 1'b0, 0));
    v = modulator;
    seed = xs(seed);
    wr_reg(vcocal_pkg::REG_FRACTION, seed[23:0]);
    step;
    step;
    `CHK("frac busy", 1'b1, busy)
    `CHK("modulator held", v, modulator)
    for (int c = 0; c < 2000 && busy === 1'b1 && load !== 1'b1; c++) step;
    wait_load(4);
    `CHK("frac load", 1'b1, load)
    `CHK("modulator", seed[23:0], modulator)
    $display("test fraction cal done");
    test_done;
  end
endmodule // tb_vcocal_seq
`default_nettype wire
